// ---- hw/lps_ctrl.sv ----
// Controller end: sensor clock, start pulse, sampling and sample FIFO
`timescale 1ns/1ps
// Overview of operation
// [RULE1] One-edge high start captured as token
// [RULE2] Token shifts through 64 stages, pixel order
// [RULE3] Stage bit falling resets its pixel integrator
// [RULE4] 65th edge releases output to high impedance
// [RULE5] Controller always supplies the 65th clock
// [RULE6] Next start no earlier than 66th clock
// [RULE7] Start drops low before the next edge
// [RULE8] Start spacing sets integration time
// [RULE9] Output released whenever no scan runs
// [RULE10] Start spacing within 0.017 to 100 ms
// [RULE11] Sensor clock within 5 to 5000 kHz
// [RULE12] One sample per period, 64 per scan
module lps_ctrl
  import lps_pkg::*;
#(
  parameter int SCLK_KHZ = DEF_SCLK_KHZ,
  parameter int INT_US   = DEF_INT_US,
  parameter int NPIX     = NUM_PIXELS,
  parameter int DEPTH    = FIFO_DEPTH
) (
  input  wire logic               ref_clk,
  input  wire logic               rst,
  lps_if.ctl                      link,
  input  wire logic               run,
  output logic [PIX_W-1:0]        sample_data,
  output logic [IDX_W-1:0]        sample_index,
  output logic                    sample_released,
  output logic                    sample_valid,
  input  wire logic               sample_ready,
  output logic                    busy,
  output logic                    scan_done
);
  // ----------------------------------------------------------------
  // Derived timing
  // ----------------------------------------------------------------
  localparam int HALF    = CLK_FREQ_KHZ / (2 * SCLK_KHZ);
  localparam int SPACING = (INT_US * SCLK_KHZ) / US_PER_MS;
  localparam int FW      = PIX_W + IDX_W + 1;

  initial begin
    if (SCLK_KHZ < SCLK_MIN_KHZ || SCLK_KHZ > SCLK_MAX_KHZ)       // [RULE11]
      $error("lps_ctrl: SCLK_KHZ outside recommended range");
    if (INT_US < INT_MIN_US || INT_US > INT_MAX_US)                // [RULE10]
      $error("lps_ctrl: INT_US outside recommended range");
    if (SPACING < NEXT_START_MIN - 1)                              // [RULE6]
      $error("lps_ctrl: start spacing shorter than a full scan");
    if (HALF < MIN_HALF || HALF > 65535)
      $error("lps_ctrl: sensor clock half period out of range");
    if (NPIX != END_EDGE - 1)
      $error("lps_ctrl: NPIX must match the chain length");
    if (NPIX >= (1 << IDX_W))
      $error("lps_ctrl: sample index too narrow for NPIX");
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
      $error("lps_ctrl: DEPTH must be a power of two");
  end

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SCAN = 3'b010,
    ST_REST = 3'b100
  } lps_state_e;

  lps_state_e   state;
  lps_state_e   next_state;
  logic [15:0]  hcnt;
  logic [31:0]  ecnt;
  logic         tick_raw;
  logic         tick;
  logic         rise_en;
  logic         fall_en;
  logic         sample_now;
  logic         stall;
  logic         start_due;
  logic         fifo_in_ready;
  logic [FW-1:0] fifo_in;
  logic [FW-1:0] fifo_out;

  // ----------------------------------------------------------------
  // Sensor clock divider, stalled while a sample is due and the FIFO is full
  // ----------------------------------------------------------------
  assign tick_raw   = hcnt == 16'(HALF - 1);
  assign sample_now = tick_raw & link.sclk & (state == ST_SCAN)
                      & (ecnt < 32'(NPIX));                        // [RULE12]
  assign stall      = sample_now & ~fifo_in_ready;
  assign tick       = tick_raw & ~stall;
  assign rise_en    = tick & ~link.sclk;
  assign fall_en    = tick & link.sclk;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      hcnt <= '0;
    end else if (tick) begin
      hcnt <= '0;
    end else if (!tick_raw) begin
      hcnt <= hcnt + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      link.sclk <= 1'b0;
    end else if (tick) begin
      link.sclk <= ~link.sclk;                                     // [RULE5] [RULE11]
    end
  end

  // ----------------------------------------------------------------
  // Start pulse and edge count
  // ----------------------------------------------------------------
  assign start_due = run & (state == ST_IDLE ||
                            (state == ST_REST && ecnt >= 32'(SPACING - 1)));

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      link.si <= 1'b0;
    end else if (fall_en) begin
      link.si <= start_due & ~link.si;                             // [RULE1] [RULE7] [RULE6]
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ecnt <= '0;
    end else if (rise_en) begin
      if (link.si) begin
        ecnt <= '0;                                                // [RULE8] [RULE10]
      end else if (ecnt != 32'hffffffff) begin
        ecnt <= ecnt + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Scan state
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (rise_en && link.si) begin
          next_state = ST_SCAN;
        end
      end
      ST_SCAN: begin
        if (rise_en && ecnt == 32'(END_EDGE - 2)) begin
          next_state = ST_REST;                                    // [RULE5]
        end
      end
      ST_REST: begin
        if (rise_en && link.si) begin
          next_state = ST_SCAN;                                    // [RULE6]
        end else if (!run && !link.si) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      scan_done <= 1'b0;
    end else begin
      scan_done <= (state == ST_SCAN) && (next_state == ST_REST);
    end
  end

  assign busy = state != ST_IDLE;

  // ----------------------------------------------------------------
  // Sample capture into the FIFO
  // ----------------------------------------------------------------
  assign fifo_in = {~link.pix_oe, ecnt[IDX_W-1:0], link.pixel_voltage_out};

  lps_fifo #(
    .WIDTH (FW),
    .DEPTH (DEPTH)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .in_data   (fifo_in),
    .in_valid  (sample_now),                                       // [RULE12]
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out),
    .out_valid (sample_valid),
    .out_ready (sample_ready)
  );

  assign sample_data     = fifo_out[PIX_W-1:0];
  assign sample_index    = fifo_out[PIX_W +: IDX_W];
  assign sample_released = fifo_out[FW-1];
endmodule // lps_ctrl

// ---- hw/lps_fifo.sv ----
// Sample FIFO between the controller and its user
`timescale 1ns/1ps
module lps_fifo #(
  parameter int WIDTH = 23,
  parameter int DEPTH = 8
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
      $error("lps_fifo: DEPTH must be a power of two >= 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wptr;
  logic [AW:0]      rptr;
  logic             push;
  logic             pop;

  assign in_ready  = (wptr ^ rptr) != {1'b1, {AW{1'b0}}};
  assign out_valid = wptr != rptr;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem[rptr[AW-1:0]];

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wptr[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wptr <= '0;
      rptr <= '0;
    end else begin
      if (push) begin
        wptr <= wptr + 1'b1;
      end
      if (pop) begin
        rptr <= rptr + 1'b1;
      end
    end
  end
endmodule // lps_fifo

// ---- hw/lps_if.sv ----
// Link between the scan controller and the sensor
`timescale 1ns/1ps
interface lps_if;
  import lps_pkg::*;
  logic             sclk;
  logic             si;
  logic [PIX_W-1:0] pix_data;
  logic             pix_oe;
  logic [PIX_W-1:0] pixel_voltage_out;

  // Released output reads as zero, standing in for the pulldown
  assign pixel_voltage_out = pix_oe ? pix_data : PIX_RESET;

  modport dev (input sclk, input si, output pix_data, output pix_oe);
  modport ctl (output sclk, output si, input pixel_voltage_out, input pix_oe);
endinterface

// ---- hw/lps_pkg.sv ----
// Shared constants for the linear pixel scan sequencer
package lps_pkg;
  // ----------------------------------------------------------------
  // Clock and chain geometry
  // ----------------------------------------------------------------
  localparam int CLK_FREQ_KHZ   = 40000;
  localparam int NUM_PIXELS     = 64;
  localparam int END_EDGE       = 65;
  localparam int NEXT_START_MIN = 66;
  localparam int PIX_W          = 16;
  localparam int IDX_W          = 7;
  localparam int LIGHT_W        = 8;
  // ----------------------------------------------------------------
  // Recommended operating ranges
  // ----------------------------------------------------------------
  localparam int SCLK_MIN_KHZ   = 5;
  localparam int SCLK_MAX_KHZ   = 5000;
  localparam int INT_MIN_US     = 17;
  localparam int INT_MAX_US     = 100000;
  localparam int US_PER_MS      = 1000;
  // ----------------------------------------------------------------
  // Defaults and margins
  // ----------------------------------------------------------------
  localparam int DEF_SCLK_KHZ   = 1000;
  localparam int DEF_INT_US     = 5000;
  localparam int FIFO_DEPTH     = 8;
  localparam int MIN_HALF       = 8;
  localparam int SYNC_STAGES    = 3;
  localparam logic [PIX_W-1:0] PIX_RESET = 16'h0000;

  function automatic logic [PIX_W-1:0] lps_sat_add(input logic [PIX_W-1:0] a,
                                                   input logic [LIGHT_W-1:0] b);
    logic [PIX_W:0] s;
    s = {1'b0, a} + {{(PIX_W+1-LIGHT_W){1'b0}}, b};
    lps_sat_add = s[PIX_W] ? {PIX_W{1'b1}} : s[PIX_W-1:0];
  endfunction
endpackage

// ---- hw/lps_sensor.sv ----
// Sensor end: scan chain, pixel integrators and output drive
`timescale 1ns/1ps
module lps_sensor
  import lps_pkg::*;
#(
  parameter int NPIX = NUM_PIXELS
) (
  input  wire logic               ref_clk,
  input  wire logic               rst,
  lps_if.dev                      link,
  input  wire logic [LIGHT_W-1:0] light_level,
  output logic                    scan_active
);
  initial begin
    if (NPIX < 2 || NPIX > (1 << (IDX_W - 1)))
      $error("lps_sensor: NPIX out of range");
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [SYNC_STAGES-1:0] sclk_q;
  logic [SYNC_STAGES-1:0] si_q;
  logic                   sclk_st;
  logic                   si_st;
  logic                   sclk_agree;
  logic                   si_now;
  logic                   rise;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sclk_q <= '0;
      si_q   <= '0;
    end else begin
      sclk_q <= {sclk_q[SYNC_STAGES-2:0], link.sclk};
      si_q   <= {si_q[SYNC_STAGES-2:0], link.si};
    end
  end

  assign sclk_agree = sclk_q[1] == sclk_q[2];
  assign si_now     = (si_q[1] == si_q[2]) ? si_q[2] : si_st;
  assign rise       = sclk_agree & sclk_q[2] & ~sclk_st;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sclk_st <= 1'b0;
      si_st   <= 1'b0;
    end else begin
      if (sclk_agree) begin
        sclk_st <= sclk_q[2];
      end
      si_st <= si_now;
    end
  end

  // ----------------------------------------------------------------
  // Scan chain
  // ----------------------------------------------------------------
  logic [NPIX-1:0]  chain;
  logic [NPIX-1:0]  next_chain;
  logic [IDX_W-1:0] idx;
  logic [IDX_W-1:0] next_idx;

  assign next_chain = {chain[NPIX-2:0], si_now};                  // [RULE1] [RULE2]
  assign next_idx   = si_now ? '0 :
                      (idx == IDX_W'(NPIX)) ? idx : idx + 1'b1;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      chain <= '0;
      idx   <= IDX_W'(NPIX);
    end else if (rise) begin
      chain <= next_chain;                                         // [RULE2]
      idx   <= next_idx;
    end
  end

  // ----------------------------------------------------------------
  // Pixel integrators
  // ----------------------------------------------------------------
  logic [PIX_W-1:0] acc [NPIX];

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      for (int k = 0; k < NPIX; k++) begin
        acc[k] <= PIX_RESET;
      end
    end else begin
      for (int k = 0; k < NPIX; k++) begin
        if (rise && chain[k] && !next_chain[k]) begin
          acc[k] <= PIX_RESET;                                     // [RULE3] [RULE8]
        end else begin
          acc[k] <= lps_sat_add(acc[k], light_level);              // [RULE8]
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Output drive
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      link.pix_data <= PIX_RESET;
      link.pix_oe   <= 1'b0;
    end else if (rise) begin
      link.pix_oe <= |next_chain;                                  // [RULE4] [RULE9]
      if (|next_chain && next_idx < IDX_W'(NPIX)) begin
        link.pix_data <= acc[next_idx[IDX_W-2:0]];                 // [RULE2]
      end else begin
        link.pix_data <= PIX_RESET;
      end
    end
  end

  assign scan_active = link.pix_oe;
endmodule // lps_sensor

// ---- test/linear_pixel_scan_sequencer_tb.sv ----
// Self-checking bench for the linear pixel scan sequencer
`timescale 1ns/1ps
module linear_pixel_scan_sequencer_tb;
  import lps_pkg::*;
  localparam int SK   = 2500;
  localparam int IU   = 30;
  localparam int SPAN = 1184;
  logic               ref_clk;
  logic               rst;
  logic               run;
  logic [LIGHT_W-1:0] light_level;
  logic               sample_ready = 1'b0;
  logic [PIX_W-1:0]   sample_data;
  logic [IDX_W-1:0]   sample_index;
  logic               sample_released;
  logic               sample_valid;
  logic               busy;
  logic               scan_done;
  logic               scan_active;
  logic [31:0]        rs = 32'h0000002c;
  int                 miscompares = 0;
  int                 compares = 0;
  int                 exp_idx = 0;
  int                 settled = 0;
  int                 words = 0;
  int                 dones = 0;
  int                 cur_l = 0;
  int                 w0;
  bit                 hold = 0;
  bit                 mix = 0;

  lps_if lnk();
  lps_sensor #(.NPIX(NUM_PIXELS)) i_lps_sensor (.ref_clk(ref_clk), .rst(rst), .link(lnk),
    .light_level(light_level), .scan_active(scan_active));
  lps_ctrl #(.SCLK_KHZ(SK), .INT_US(IU), .NPIX(NUM_PIXELS), .DEPTH(FIFO_DEPTH)) i_lps_ctrl (
    .ref_clk(ref_clk), .rst(rst), .link(lnk), .run(run), .sample_data(sample_data),
    .sample_index(sample_index), .sample_released(sample_released),
    .sample_valid(sample_valid), .sample_ready(sample_ready), .busy(busy),
    .scan_done(scan_done));
  lps_link_properties #(.SCLK_KHZ(SK)) i_lps_link_properties (.ref_clk(ref_clk), .rst(rst),
    .sclk(lnk.sclk), .si(lnk.si), .pix_data(lnk.pix_data), .pix_oe(lnk.pix_oe));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  function automatic logic in_win(input logic [PIX_W-1:0] d);
    int lo;
    int hi;
    lo = (cur_l * (SPAN - 32) > 65535) ? 65535 : cur_l * (SPAN - 32);
    hi = (cur_l * (SPAN + 32) > 65535) ? 65535 : cur_l * (SPAN + 32);
    return (d >= lo) && (d <= hi);
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic wait_words(input int n);
    int t;
    t = words + n;
    while (words < t) @(posedge ref_clk);
  endtask
  task automatic wrap_up();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Clock, watchdog and sample consumer with reference model
  // ----------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  initial begin
    #1000000;
    miscompares++;
    $display("[FAIL] %0t watchdog expired", $time);
    wrap_up();
  end
  always @(posedge ref_clk) begin
    if (!rst && sample_valid === 1'b1 && sample_ready === 1'b1) begin
      chk(32'(sample_index), exp_idx);
      chk(32'(sample_released), 0);
      if (settled >= 3) chk(32'(in_win(sample_data)), 1);
      exp_idx = (exp_idx + 1) % NUM_PIXELS;
      if (exp_idx == 0) settled++;
      words++;
    end
    if (scan_done === 1'b1) dones++;
    sample_ready <= hold ? 1'b0 : (mix ? 1'(xs()) : 1'b1);
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    run = 1'b0;
    light_level = 8'h00;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    cur_l = int'(xs() % 15) + 1;
    @(posedge ref_clk);
    light_level <= 8'(cur_l);
    run <= 1'b1;
    wait_words(320);
    @(negedge ref_clk);
    mix = 1;
    wait_words(128);
    @(negedge ref_clk);
    mix = 0;
    hold = 1;
    repeat (400) @(posedge ref_clk);
    chk(32'(sample_valid), 1);
    chk(32'(lnk.sclk), 1);
    @(negedge ref_clk);
    hold = 0;
    settled = 0;
    cur_l = 255;
    @(posedge ref_clk);
    light_level <= 8'hff;
    wait_words(256);
    run <= 1'b0;
    for (int i = 0; i < 4000 && busy !== 1'b0; i++) @(posedge ref_clk);
    repeat (200) @(posedge ref_clk);
    chk(32'(busy), 0);
    chk(32'(scan_active), 0);
    w0 = words;
    repeat (2000) @(posedge ref_clk);
    chk(words, w0);
    chk(words % NUM_PIXELS, 0);
    chk(dones * NUM_PIXELS, words);
    wrap_up();
  end
endmodule // linear_pixel_scan_sequencer_tb

// ---- test/lps_link_properties.sv ----
// Link checker between the scan controller and the sensor
`timescale 1ns/1ps
module lps_link_properties
  import lps_pkg::*;
#(
  parameter int SCLK_KHZ = DEF_SCLK_KHZ
) (
  input wire logic             ref_clk,
  input wire logic             rst,
  input wire logic             sclk,
  input wire logic             si,
  input wire logic [PIX_W-1:0] pix_data,
  input wire logic             pix_oe
);
  localparam int HALF = CLK_FREQ_KHZ / SCLK_KHZ / 2;
  logic       sclk_q;
  logic       fell_seen;
  logic [6:0] edge_cnt;
  logic [7:0] low_cnt;
  logic       rise;

  assign rise = sclk && !sclk_q;
  // ----------------------------------------------------------------
  // Helper counters
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sclk_q    <= 1'b0;
      fell_seen <= 1'b0;
    end else begin
      sclk_q    <= sclk;
      fell_seen <= fell_seen || (sclk_q && !sclk);
    end
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) edge_cnt <= 7'h42;
    else if (rise && si) edge_cnt <= 7'h01;
    else if (rise && edge_cnt < 7'h42) edge_cnt <= edge_cnt + 7'h01;
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) low_cnt <= 8'h00;
    else if (sclk) low_cnt <= 8'h00;
    else low_cnt <= low_cnt + 8'h01;
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_start;
    rise && si;
  endsequence
  sequence s_quiet;
    $stable(pix_data)[*4];
  endsequence

  a_start_at_fall: assert property ($rose(si) |-> $fell(sclk))
    else $error("start rose away from a clock fall");
  a_single_token: assert property (rise && edge_cnt == 7'h01 |-> !si)
    else $error("start still high at second edge");
  a_oe_first_edge: assert property (s_start |-> ##[3:5] $rose(pix_oe))
    else $error("output not driven after start edge");
  a_oe_from_start: assert property ($rose(pix_oe) |-> edge_cnt == 7'h01)
    else $error("output driven outside first stage");
  a_oe_last_edge: assert property (rise && edge_cnt == 7'h40 |-> ##[3:5] $fell(pix_oe))
    else $error("output not released at edge 65");
  a_end_on_final: assert property ($fell(pix_oe) |-> edge_cnt == 7'h41)
    else $error("output released before edge 65");
  a_idle_released: assert property (edge_cnt == 7'h42 |-> !pix_oe)
    else $error("output driven while idle");
  a_restart_spacing: assert property (s_start |-> edge_cnt >= 7'h41)
    else $error("start before edge 66");
  a_data_stands: assert property ($fell(sclk) |-> s_quiet)
    else $error("pixel word changed in low phase");
  a_low_half: assert property (rise && fell_seen |-> low_cnt == HALF)
    else $error("clock low phase length wrong");
endmodule // lps_link_properties
